// >>> design/ssc_regs.sv
/*
 Sync status and control register bank: pin synchronisers, activity and
 polarity detection, line sync window filter, lines-per-frame counter,
 auto-offset loop with hold, interrupt status and the Wishbone slave.
 Assumes sync pins are asynchronous to clk_in and the offset target comes
 from logic on clk_in.
*/
`timescale 1ns/1ps
`include "ssc_consts.svh"

// Operation
// R01: PLL follows raw or windowed line sync
// R02: Processing uses raw or regenerated line sync
// R03: Software sets select bit zero, keeps defaults
// R04: Window width in 25 ns steps
// R05: Activity bits for line, frame, green
// R06: Activity bit for clock or hold pin
// R07: Activity bit for clamp pin
// R08: Polarity bits for line and frame
// R09: Polarity bits for hold and clamp
// R10: Extraneous pulse flag from line filter
// R11: Lock flag of line sync filter
// R12: Twelve-bit lines per frame counter
// R13: Software writes fixed test values
// R14: Read-only test registers ignore writes
// R15: Software keeps other hold bits zero
// R16: Hold bit freezes offset loop
// R17: Software sequence for one-time calibration
// R18: Offset settles within ten updates
// R19: Activity times out, reads never clear
module ssc_regs
    import ssc_pkg::*;
#(
    parameter int CNT_W        = 16,
    parameter int ACT_W        = 24,
    parameter int ACT_TIMEOUT  = `SSC_ACT_TIMEOUT_CYC,
    parameter int OFFS_W       = 10
)(
    input  wire logic              clk_in,
    input  wire logic              rstn_in,
    input  wire ssc_wb_req_t       wb_req_in,
    output logic [31:0]            wb_dat_out,
    output logic                   wb_ack_out,
    input  wire logic              line_sync_in0_in,
    input  wire logic              line_sync_in1_in,
    input  wire logic              frame_sync_in0_in,
    input  wire logic              frame_sync_in1_in,
    input  wire logic              green_sync_in0_in,
    input  wire logic              green_sync_in1_in,
    input  wire logic              ext_clock_or_hold_pin_in,
    input  wire logic              clamp_pin_in,
    input  wire logic [OFFS_W-1:0] offset_target_in,
    output logic [OFFS_W-1:0]      offset_value_out,
    output logic                   pll_ref_out,
    output logic                   proc_sync_out,
    output logic                   irq_out
);

    localparam logic [ACT_W-1:0] ACT_LAST = ACT_W'(ACT_TIMEOUT - 1);

    // Software registers and interrupt terms
    logic [7:0]        sync_sel_r, def_a_r, def_b_r, win_r, test1_r, test2_r;
    logic [7:0]        hold_r, loop_ctl_r, interval_r;
    logic [4:0]        irq_st_r, irq_mask_r, irq_ev, irq_clr;
    logic              ack_r;
    logic [31:0]       rdat_r;

    // Pin bank
    logic [7:0]        pins, s1_r, s2_r, s3_r, lvl_r, edge_w, pol_r, act_r, act_prev_r;
    logic [CNT_W-1:0]  run_r     [8];
    logic [CNT_W-1:0]  hi_len_r  [8];
    logic [CNT_W-1:0]  lo_len_r  [8];
    logic [ACT_W-1:0]  act_cnt_r [8];

    // Filter, counters and offset loop
    ssc_filt_state_t   fstate_r;
    logic [CNT_W-1:0]  pos_r, period_r, win_cyc;
    logic [1:0]        good_r;
    logic [11:0]       line_cnt_r, lpf_r;
    logic [7:0]        upd_cnt_r;
    logic [OFFS_W-1:0] offs_r;
    logic              extr_r, pll_ref_r, proc_sync_r, pass_r;

    // Bus decode and combinational terms
    logic [5:0]        idx;
    logic [7:0]        act_byte, pol_byte;
    logic [2:0]        line_idx, frame_idx;
    logic              req, wr_en, mapped, line_pol, raw_norm, raw_lead, frame_lead;
    logic              locked, in_win, miss, regen, proc_line, upd_tick;

    // Window test around the expected leading edge
    function automatic logic ssc_in_win(input logic [CNT_W-1:0] pos,
                                        input logic [CNT_W-1:0] per,
                                        input logic [CNT_W-1:0] w);
        logic [CNT_W:0] lo_sum;
        logic [CNT_W:0] hi_lim;
        lo_sum = {1'b0, pos} + {1'b0, w};
        hi_lim = {1'b0, per} + {1'b0, w};
        return (lo_sum >= {1'b0, per}) && ({1'b0, pos} <= hi_lim);
    endfunction

    assign pins = {clamp_pin_in, ext_clock_or_hold_pin_in, green_sync_in1_in, green_sync_in0_in,
                   frame_sync_in1_in, frame_sync_in0_in, line_sync_in1_in, line_sync_in0_in};

    // Three-stage synchronisers; a level counts once stages two and three agree
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            s1_r  <= 8'h00;
            s2_r  <= 8'h00;
            s3_r  <= 8'h00;
            lvl_r <= 8'h00;
        end
        else
        begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int k = 0; k < 8; k++)
            begin
                if (s2_r[k] == s3_r[k])
                    lvl_r[k] <= s3_r[k];
            end
        end
    end

    // Per-pin run lengths, polarity and activity timeout
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_pin
            assign edge_w[gi] = (s2_r[gi] == s3_r[gi]) && (s3_r[gi] != lvl_r[gi]);

            // Polarity: the shorter level is the pulse, so high shorter means positive
            always_ff @(posedge clk_in or negedge rstn_in)
            begin
                if (!rstn_in)
                begin
                    run_r[gi]    <= '0;
                    hi_len_r[gi] <= '1;
                    lo_len_r[gi] <= '1;
                    pol_r[gi]    <= 1'b0;
                end
                else
                begin
                    if (edge_w[gi])
                    begin
                        run_r[gi] <= '0;
                        if (lvl_r[gi])
                            hi_len_r[gi] <= run_r[gi];
                        else
                            lo_len_r[gi] <= run_r[gi];
                    end
                    else if (run_r[gi] != '1)
                        run_r[gi] <= run_r[gi] + 1'b1;
                    pol_r[gi] <= (hi_len_r[gi] < lo_len_r[gi]); // R08 R09
                end
            end

            // Activity: an edge sets it, a silent timeout clears it, reads leave it alone
            always_ff @(posedge clk_in or negedge rstn_in)
            begin
                if (!rstn_in)
                begin
                    act_cnt_r[gi] <= '0;
                    act_r[gi]     <= 1'b0;
                end
                else if (edge_w[gi])
                begin
                    act_cnt_r[gi] <= '0; // R19
                    act_r[gi]     <= 1'b1; // R05 R06 R07
                end
                else if (act_r[gi])
                begin
                    if (act_cnt_r[gi] == ACT_LAST)
                        act_r[gi] <= 1'b0; // R19
                    act_cnt_r[gi] <= act_cnt_r[gi] + 1'b1;
                end
            end
        end
    endgenerate

    // Active line and frame inputs chosen by the loop control register
    assign line_idx   = loop_ctl_r[`SSC_BIT_LOOP_GREEN] ?
                        (`SSC_PIN_GREEN0 + {2'b00, loop_ctl_r[`SSC_BIT_LOOP_CHAN]}) :
                        (`SSC_PIN_LINE0 + {2'b00, loop_ctl_r[`SSC_BIT_LOOP_CHAN]});
    assign frame_idx  = `SSC_PIN_FRAME0 + {2'b00, loop_ctl_r[`SSC_BIT_LOOP_CHAN]};
    assign line_pol   = pol_r[line_idx];
    assign raw_norm   = ~(lvl_r[line_idx] ^ line_pol);
    assign raw_lead   = edge_w[line_idx] && (s3_r[line_idx] == line_pol);
    assign frame_lead = edge_w[frame_idx] && (s3_r[frame_idx] == pol_r[frame_idx]);
    assign locked     = (fstate_r == FS_LOCKED);
    assign win_cyc    = CNT_W'(({8'h00, win_r} * 16'(`SSC_WIN_STEP_NS)) / 16'(`SSC_CLK_PERIOD_NS)); // R04
    assign in_win     = ssc_in_win(pos_r, period_r, win_cyc);
    assign miss       = locked && ({1'b0, pos_r} > ({1'b0, period_r} + {1'b0, win_cyc}));
    assign regen      = (locked && raw_lead && in_win) || miss;
    assign proc_line  = sync_sel_r[`SSC_BIT_PROC_REGEN] ? regen : raw_lead; // R02

    // Line filter: learns the period, passes edges inside the window, flywheels on a miss
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            fstate_r <= FS_SEARCH;
            pos_r    <= '0;
            period_r <= '0;
            good_r   <= 2'h0;
        end
        else if (raw_lead && (!locked || in_win))
        begin
            period_r <= pos_r;
            pos_r    <= '0;
            if (!locked)
            begin
                good_r <= in_win ? good_r + 2'h1 : 2'h0;
                if (in_win && (good_r + 2'h1 >= `SSC_LOCK_GOOD))
                    fstate_r <= FS_LOCKED; // R11
            end
        end
        else if (miss)
        begin
            fstate_r <= FS_SEARCH; // R11
            good_r   <= 2'h0;
            pos_r    <= win_cyc;
        end
        else if (pos_r != '1)
            pos_r <= pos_r + 1'b1;
    end

    // Extraneous pulses inside a locked line; cleared per frame, a new pulse wins
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            extr_r <= 1'b0;
        else if (locked && raw_lead && !in_win)
            extr_r <= 1'b1; // R10
        else if (frame_lead)
            extr_r <= 1'b0;
    end

    // Lines per frame, latched at each frame leading edge
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            line_cnt_r <= 12'h000;
            lpf_r      <= 12'h000;
        end
        else if (frame_lead)
        begin
            lpf_r      <= line_cnt_r; // R12
            line_cnt_r <= {11'h000, proc_line};
        end
        else if (proc_line && (line_cnt_r != 12'hFFF))
            line_cnt_r <= line_cnt_r + 12'h001; // R12
    end

    // Filtered reference: a pulse passes if its leading edge fell in the window or the filter is unlocked
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            pass_r <= 1'b0;
        else if (raw_lead)
            pass_r <= in_win || !locked; // R01
        else if (edge_w[line_idx])
            pass_r <= 1'b0;
    end

    // Sync outputs toward the PLL and the sync processor
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            pll_ref_r   <= 1'b0;
            proc_sync_r <= 1'b0;
        end
        else
        begin
            pll_ref_r   <= sync_sel_r[`SSC_BIT_PLL_FILT] ? (raw_norm && pass_r) : raw_norm; // R01
            proc_sync_r <= proc_line; // R02
        end
    end

    // Offset loop: halving steps reach a ten-bit target in ten updates
    assign upd_tick = proc_line && (upd_cnt_r >= interval_r);
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            upd_cnt_r <= 8'h00;
            offs_r    <= '0;
        end
        else
        begin
            if (upd_tick)
                upd_cnt_r <= 8'h00;
            else if (proc_line)
                upd_cnt_r <= upd_cnt_r + 8'h01;
            if (upd_tick && loop_ctl_r[`SSC_BIT_LOOP_EN] && !hold_r[`SSC_BIT_OFFS_HOLD]) // R16
            begin
                if (offset_target_in > offs_r)
                    offs_r <= offs_r + OFFS_W'(({1'b0, offset_target_in} - {1'b0, offs_r} + 1'b1) >> 1); // R18
                else if (offset_target_in < offs_r)
                    offs_r <= offs_r - OFFS_W'(({1'b0, offs_r} - {1'b0, offset_target_in} + 1'b1) >> 1); // R18
            end
        end
    end

    // Bus decode; a misaligned or unknown address answers with zero
    assign idx      = wb_req_in.adr[7:2];
    assign req      = wb_req_in.cyc && wb_req_in.stb;
    assign mapped   = (wb_req_in.adr[1:0] == 2'b00);
    assign wr_en    = req && ack_r && wb_req_in.we && wb_req_in.sel[0] && (wb_req_in.adr[1:0] == 2'b00);
    assign act_byte = {act_r[0], act_r[1], act_r[2], act_r[3], act_r[4], act_r[5], act_r[6], act_r[7]};
    assign pol_byte = {pol_r[0], pol_r[1], pol_r[2], pol_r[3], pol_r[`SSC_PIN_COAST],
                       pol_r[`SSC_PIN_CLAMP], extr_r, locked}; // R08 R09 R10 R11
    assign irq_ev   = {|(act_r ^ act_prev_r), frame_lead, locked && raw_lead && !in_win, miss,
                       raw_lead && !locked && in_win && (good_r + 2'h1 >= `SSC_LOCK_GOOD)};
    assign irq_clr  = (wr_en && (idx == `SSC_IDX_IRQ_STATUS)) ? wb_req_in.dat[4:0] : 5'h00;

    // Writes land at the edge where the master sees ack; read-only indices ignore them
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            sync_sel_r <= `SSC_RST_SYNC_SEL;
            def_a_r    <= `SSC_RST_DEF_A;
            def_b_r    <= `SSC_RST_DEF_B;
            win_r      <= `SSC_RST_WIN_WIDTH;
            test1_r    <= `SSC_RST_TEST;
            test2_r    <= `SSC_RST_TEST;
            hold_r     <= `SSC_RST_OFFS_HOLD;
            loop_ctl_r <= `SSC_RST_LOOP_CTL;
            interval_r <= `SSC_RST_UPD_INTERVAL;
            irq_mask_r <= 5'h00;
        end
        else if (wr_en)
        begin
            case (idx)
                `SSC_IDX_SYNC_SEL:     sync_sel_r <= wb_req_in.dat[7:0];
                `SSC_IDX_DEF_A:        def_a_r    <= wb_req_in.dat[7:0];
                `SSC_IDX_DEF_B:        def_b_r    <= wb_req_in.dat[7:0];
                `SSC_IDX_WIN_WIDTH:    win_r      <= wb_req_in.dat[7:0];
                `SSC_IDX_TEST_ONE:     test1_r    <= wb_req_in.dat[7:0];
                `SSC_IDX_TEST_TWO:     test2_r    <= wb_req_in.dat[7:0];
                `SSC_IDX_OFFS_HOLD:    hold_r     <= wb_req_in.dat[7:0];
                `SSC_IDX_LOOP_CTL:     loop_ctl_r <= wb_req_in.dat[7:0];
                `SSC_IDX_UPD_INTERVAL: interval_r <= wb_req_in.dat[7:0];
                `SSC_IDX_IRQ_MASK:     irq_mask_r <= wb_req_in.dat[4:0];
                default:               ; // R14
            endcase
        end
    end

    // Sticky events; an event in the clearing cycle survives
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            irq_st_r   <= 5'h00;
            act_prev_r <= 8'h00;
        end
        else
        begin
            irq_st_r   <= (irq_st_r & ~irq_clr) | irq_ev;
            act_prev_r <= act_r;
        end
    end

    // Ack one cycle after the request, read data captured with it
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r  <= req && !ack_r;
            rdat_r <= 32'h0000_0000;
            if (req && !ack_r && mapped)
            begin
                unique case (idx)
                    `SSC_IDX_SYNC_SEL:     rdat_r[7:0] <= sync_sel_r;
                    `SSC_IDX_DEF_A:        rdat_r[7:0] <= def_a_r;
                    `SSC_IDX_DEF_B:        rdat_r[7:0] <= def_b_r;
                    `SSC_IDX_WIN_WIDTH:    rdat_r[7:0] <= win_r;
                    `SSC_IDX_ACT_STATUS:   rdat_r[7:0] <= act_byte; // R05 R06 R07
                    `SSC_IDX_POL_STATUS:   rdat_r[7:0] <= pol_byte;
                    `SSC_IDX_LPF_HIGH:     rdat_r[7:0] <= lpf_r[11:4]; // R12
                    `SSC_IDX_LPF_LOW:      rdat_r[7:0] <= {lpf_r[3:0], 4'h0}; // R12
                    `SSC_IDX_TEST_ONE:     rdat_r[7:0] <= test1_r;
                    `SSC_IDX_TEST_TWO:     rdat_r[7:0] <= test2_r;
                    `SSC_IDX_TEST_THREE:   rdat_r[7:0] <= `SSC_RO_TEST_THREE; // R14
                    `SSC_IDX_TEST_FOUR:    rdat_r[7:0] <= `SSC_RO_TEST_FOUR; // R14
                    `SSC_IDX_OFFS_HOLD:    rdat_r[7:0] <= hold_r;
                    `SSC_IDX_IRQ_STATUS:   rdat_r[4:0] <= irq_st_r;
                    `SSC_IDX_IRQ_MASK:     rdat_r[4:0] <= irq_mask_r;
                    `SSC_IDX_LOOP_CTL:     rdat_r[7:0] <= loop_ctl_r;
                    `SSC_IDX_UPD_INTERVAL: rdat_r[7:0] <= interval_r;
                    default:               rdat_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign wb_ack_out       = ack_r;
    assign wb_dat_out       = rdat_r;
    assign irq_out          = |(irq_st_r & irq_mask_r);
    assign offset_value_out = offs_r;
    assign pll_ref_out      = pll_ref_r;
    assign proc_sync_out    = proc_sync_r;

    // Helper: updates since the offset target last moved
    logic [3:0]        settle_cnt_r;
    logic [OFFS_W-1:0] tgt_prev_r;
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            settle_cnt_r <= 4'h0;
            tgt_prev_r   <= '0;
        end
        else
        begin
            tgt_prev_r <= offset_target_in;
            if ((tgt_prev_r != offset_target_in) || hold_r[`SSC_BIT_OFFS_HOLD] || !loop_ctl_r[`SSC_BIT_LOOP_EN])
                settle_cnt_r <= 4'h0;
            else if (upd_tick && (settle_cnt_r != 4'hF))
                settle_cnt_r <= settle_cnt_r + 4'h1;
        end
    end

    sequence s_held_two;
        hold_r[`SSC_BIT_OFFS_HOLD] ##1 hold_r[`SSC_BIT_OFFS_HOLD];
    endsequence

    sequence s_bus_write_ro;
        wr_en && (idx == `SSC_IDX_TEST_THREE);
    endsequence

    a_pll_source: assert property (@(posedge clk_in) disable iff (!rstn_in) // R01
        !sync_sel_r[`SSC_BIT_PLL_FILT] |=> (pll_ref_r == $past(raw_norm)))
        else $error("pll reference not raw sync with filter off");
    a_proc_source: assert property (@(posedge clk_in) disable iff (!rstn_in) // R02
        (sync_sel_r[`SSC_BIT_PROC_REGEN] && miss) |=> proc_sync_r)
        else $error("regenerated sync missing on processing output");
    a_activity_set: assert property (@(posedge clk_in) disable iff (!rstn_in) // R05
        edge_w[0] |=> act_r[0] [*2])
        else $error("activity not reported after edge");
    a_activity_drop: assert property (@(posedge clk_in) disable iff (!rstn_in) // R19
        (act_r[7] && act_cnt_r[7] == ACT_LAST && !edge_w[7]) |=> !act_r[7])
        else $error("clamp activity did not time out");
    a_extra_pulse: assert property (@(posedge clk_in) disable iff (!rstn_in) // R10
        (locked && raw_lead && !in_win) |=> extr_r ##0 pol_byte[1])
        else $error("extraneous pulse not flagged");
    a_lock_drop: assert property (@(posedge clk_in) disable iff (!rstn_in) // R11
        miss |=> (fstate_r == FS_SEARCH) && !pol_byte[0])
        else $error("lock flag kept after miss");
    a_lpf_latch: assert property (@(posedge clk_in) disable iff (!rstn_in) // R12
        frame_lead |=> (lpf_r == $past(line_cnt_r)))
        else $error("lines per frame not latched");
    a_ro_ignore: assert property (@(posedge clk_in) disable iff (!rstn_in) // R14
        s_bus_write_ro |=> $stable({sync_sel_r, win_r, test1_r, test2_r, hold_r, loop_ctl_r}))
        else $error("write to read-only index disturbed a register");
    a_hold_freeze: assert property (@(posedge clk_in) disable iff (!rstn_in) // R16
        s_held_two |-> $stable(offs_r))
        else $error("offset moved while held");
    a_settle_bound: assert property (@(posedge clk_in) disable iff (!rstn_in) // R18
        (settle_cnt_r == 4'(`SSC_SETTLE_UPDATES)) && (tgt_prev_r == offset_target_in) |-> (offs_r == offset_target_in))
        else $error("offset not settled after ten updates");

endmodule

// >>> design/ssc_consts.svh
/*
 Register indices, field positions, reset values and timing figures of the
 sync status and control register bank.
 Assumes a 100 MHz core clock and a bus byte address equal to four times the index.
*/
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH

// Register indices, byte address is index * 4
`define SSC_IDX_SYNC_SEL      6'h20
`define SSC_IDX_DEF_A         6'h21
`define SSC_IDX_DEF_B         6'h22
`define SSC_IDX_WIN_WIDTH     6'h23
`define SSC_IDX_ACT_STATUS    6'h24
`define SSC_IDX_POL_STATUS    6'h25
`define SSC_IDX_LPF_HIGH      6'h26
`define SSC_IDX_LPF_LOW       6'h27
`define SSC_IDX_TEST_ONE      6'h28
`define SSC_IDX_TEST_TWO      6'h29
`define SSC_IDX_TEST_THREE    6'h2A
`define SSC_IDX_TEST_FOUR     6'h2B
`define SSC_IDX_OFFS_HOLD     6'h2C
`define SSC_IDX_IRQ_STATUS    6'h30
`define SSC_IDX_IRQ_MASK      6'h31
`define SSC_IDX_LOOP_CTL      6'h32
`define SSC_IDX_UPD_INTERVAL  6'h33

// Reset values
`define SSC_RST_SYNC_SEL      8'h08
`define SSC_RST_DEF_A         8'h00
`define SSC_RST_DEF_B         8'h00
`define SSC_RST_WIN_WIDTH     8'h0A
`define SSC_RST_TEST          8'h00
`define SSC_RST_OFFS_HOLD     8'h00
`define SSC_RST_LOOP_CTL      8'h00
`define SSC_RST_UPD_INTERVAL  8'h40
`define SSC_RO_TEST_THREE     8'h00
`define SSC_RO_TEST_FOUR      8'h00

// Field positions
`define SSC_BIT_PLL_FILT      2
`define SSC_BIT_PROC_REGEN    1
`define SSC_BIT_OFFS_HOLD     4
`define SSC_BIT_LOOP_EN       0
`define SSC_BIT_LOOP_CHAN     1
`define SSC_BIT_LOOP_GREEN    2

// Pin slots in the synchroniser bank
`define SSC_PIN_LINE0         3'h0
`define SSC_PIN_FRAME0        3'h2
`define SSC_PIN_GREEN0        3'h4
`define SSC_PIN_COAST         6
`define SSC_PIN_CLAMP         7

// Timing
`define SSC_CLK_PERIOD_NS     10
`define SSC_WIN_STEP_NS       25
`define SSC_ACT_TIMEOUT_NS    100000000
`define SSC_ACT_TIMEOUT_CYC   (`SSC_ACT_TIMEOUT_NS / `SSC_CLK_PERIOD_NS)
`define SSC_SETTLE_UPDATES    10
`define SSC_LOCK_GOOD         2'h2

`endif

// >>> design/ssc_pkg.sv
/*
 Types of the sync status and control register bank.
 Assumes the constants header is included by every user of the package.
*/
package ssc_pkg;

    // Classic Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } ssc_wb_req_t;

    // Line sync filter state
    typedef enum logic [1:0] {
        FS_SEARCH = 2'b01,
        FS_LOCKED = 2'b10
    } ssc_filt_state_t;

endpackage

// >>> testbench/ssc_src.sv
/* Video source model driving line, frame and clamp pins.
   Assumes one clock; pins rest low while run_in is low; extra_in adds mid-line pulses. */
`timescale 1ns/1ps
module ssc_src (
    input  wire logic clk_in,
    input  wire logic run_in,
    input  wire logic extra_in,
    output logic      line_out,
    output logic      frame_out,
    output logic      clamp_out
);
    logic [8:0] t_r = 9'h000;
    // Short high pulses, so every pin measures positive
    always_ff @(posedge clk_in)
    begin
        t_r       <= (t_r == 9'h13F) ? 9'h000 : t_r + 9'h001;
        line_out  <= run_in && ((t_r % 9'h028 < 9'h004) ||
                     (extra_in && (t_r % 9'h028 >= 9'h014) && (t_r % 9'h028 < 9'h018)));
        frame_out <= run_in && (t_r >= 9'h014) && (t_r < 9'h018); // Mid-line, 8 lines
        // Three cycles wide, a single-cycle pulse never passes the glitch filter
        clamp_out <= run_in && (t_r % 9'h028 >= 9'h00A) && (t_r % 9'h028 < 9'h00D);
    end
endmodule

// >>> testbench/ssc_regs_bench.sv
/* Self-checking bench of the sync status register bank.
   Assumes the slave acks each Wishbone request. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fail_count++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module ssc_regs_bench;
    import ssc_pkg::*;
    logic        clk_in = 0, rstn_in = 0, run = 0, ln, fr, cl, ack, irq;
    logic        xp = 0, ps, pr;
    int          ps_n, pr_n;
    logic [31:0] dat;
    logic [9:0]  tgt = 10'h200, offs;
    ssc_wb_req_t req = '0;
    int          fail_count = 0, cmp_count = 0;
    always #5 clk_in = ~clk_in;
    ssc_src src (.clk_in(clk_in), .run_in(run), .extra_in(xp), .line_out(ln), .frame_out(fr), .clamp_out(cl));
    ssc_regs #(.ACT_TIMEOUT(400)) dut (.clk_in(clk_in), .rstn_in(rstn_in), .wb_req_in(req),
        .wb_dat_out(dat), .wb_ack_out(ack), .line_sync_in0_in(ln), .line_sync_in1_in(ln),
        .frame_sync_in0_in(fr), .frame_sync_in1_in(fr), .green_sync_in0_in(ln),
        .green_sync_in1_in(ln), .ext_clock_or_hold_pin_in(fr), .clamp_pin_in(cl),
        .offset_target_in(tgt), .offset_value_out(offs), .pll_ref_out(pr), .proc_sync_out(ps),
        .irq_out(irq));
    // Request held until ack is sampled high
    task bus(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        @(posedge clk_in);
        req <= '{1'b1, 1'b1, w, 4'hF, a, {24'h000000, d}};
        do @(posedge clk_in); while (ack !== 1'b1);
        q = dat[7:0];
        req <= '0;
    endtask
    task wr(input logic [7:0] a, d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task rc(input logic [7:0] a, e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        `CHK("reg", e, q)
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Watchdog, run needs about 4400 cycles
    initial
    begin
        #200000;
        fail_count++;
        give_verdict;
    end
    // Main sequence
    initial
    begin
        repeat (2) @(posedge clk_in);
        rstn_in <= 1'b1;
        rc(8'h80, 8'h08);
        rc(8'h8C, 8'h0A);
        rc(8'hCC, 8'h40);
        rc(8'h90, 8'h00);
        wr(8'h80, 8'h09);
        wr(8'hA0, 8'hBF);
        wr(8'hA4, 8'h02);
        wr(8'hA8, 8'h5A);
        rc(8'hA0, 8'hBF);
        rc(8'hA8, 8'h00);
        wr(8'hFC, 8'hFF);
        rc(8'hFC, 8'h00);
        run <= 1'b1;
        repeat (1200) @(posedge clk_in);
        rc(8'h90, 8'hFF);
        rc(8'h94, 8'hFD);
        rc(8'h98, 8'h00);
        rc(8'h9C, 8'h80);
        wr(8'hC4, 8'h01);
        @(posedge clk_in);
        `CHK("irq", 1'b1, irq)
        wr(8'hC0, 8'h01);
        @(posedge clk_in);
        `CHK("irq", 1'b0, irq)
        // Interval 1 updates every second line, ten updates fit in 1000 cycles
        wr(8'hCC, 8'h01);
        wr(8'hC8, 8'h01);
        repeat (1000) @(posedge clk_in);
        `CHK("offs", 10'h200, offs)
        wr(8'hB0, 8'h10);
        tgt <= 10'h000;
        repeat (600) @(posedge clk_in);
        `CHK("offs", 10'h200, offs)
        // Ten-cycle window, filtered PLL, regenerated sync, extra mid-line pulses
        wr(8'h8C, 8'h04);
        wr(8'h80, 8'h0F);
        xp <= 1'b1;
        repeat (700) @(posedge clk_in);
        rc(8'h94, 8'hFF);
        rc(8'h9C, 8'h80);
        ps_n = 0;
        pr_n = 0;
        repeat (320)
        begin
            @(posedge clk_in);
            ps_n += ps;
            pr_n += pr;
        end
        `CHK("proc", 8, ps_n)
        `CHK("pll", 32, pr_n)
        xp <= 1'b0;
        run <= 1'b0;
        repeat (500) @(posedge clk_in);
        rc(8'h90, 8'h00);
        give_verdict;
    end
endmodule
